/* rtl/arcm_pkg.sv */
// constants, types and register map of the receive clock, mode and burst-detect block
package arcm_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int HI_RATE_HZ = 88_200;
  localparam int LO_RATE_HZ = 54_000;
  localparam int LOCK_MIN_HZ = 22_000;
  localparam int LOCK_MAX_HZ = 108_000;
  localparam int PER_W = 9;
  // longest frame period still counted as high rate, rounded down
  localparam logic [PER_W-1:0] HI_MAX_CYC = PER_W'(CLK_HZ / HI_RATE_HZ);
  // shortest frame period counted as low rate, rounded up
  localparam logic [PER_W-1:0] LO_MIN_CYC = PER_W'((CLK_HZ + LO_RATE_HZ - 1) / LO_RATE_HZ);
  localparam logic [PER_W-1:0] LOCK_MIN_CYC = PER_W'(CLK_HZ / LOCK_MAX_HZ);
  localparam logic [PER_W-1:0] LOCK_MAX_CYC = PER_W'((CLK_HZ + LOCK_MIN_HZ - 1) / LOCK_MIN_HZ);
  localparam logic [PER_W-1:0] PER_SAT = {PER_W{1'b1}};
  localparam logic [3:0] LOCK_FRAMES = 4'h8;
  localparam int FRM_W = 12;
  localparam logic [FRM_W-1:0] IDLE_LAST = {FRM_W{1'b1}};

  // --------------------------------------------------------------
  // burst sync pattern
  // --------------------------------------------------------------
  localparam logic [2:0] SYNC_ZERO_WORDS = 3'h5;
  localparam logic [15:0] SYNC_WORD_A = 16'hF872;
  localparam logic [15:0] SYNC_WORD_B = 16'h4E1F;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_EVENT = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_BUF0 = 5'h0D;
  localparam logic [ADDR_W-1:0] ADDR_BUF1 = 5'h0E;
  localparam logic [ADDR_W-1:0] ADDR_BUF2 = 5'h0F;
  localparam logic [ADDR_W-1:0] ADDR_BUF3 = 5'h10;
  localparam int CTRL_W = 5;
  localparam int EV_W = 3;
  localparam int EV_BURST = 0;
  localparam int EV_UNLOCK = 1;
  localparam int EV_IDLE = 2;
  localparam int ST_LOCK = 0;
  localparam int ST_HIRATE = 1;
  localparam int ST_COMP = 2;
  localparam int ST_XTAL = 3;

  typedef enum logic [1:0] {
    MODE_PLL = 2'h0,
    MODE_XTAL = 2'h1,
    MODE_AUTO = 2'h2,
    MODE_MON = 2'h3
  } arcm_mode_e;

  typedef enum logic [1:0] {
    OCS_256_256 = 2'h0,
    OCS_256_128 = 2'h1,
    OCS_512_256 = 2'h2,
    OCS_TEST = 2'h3
  } arcm_ocs_e;

  typedef enum logic [1:0] {
    BS_SEEK = 2'h0,
    BS_SAW_A = 2'h1,
    BS_CAP_INFO = 2'h3,
    BS_CAP_LEN = 2'h2
  } arcm_burst_e;

  typedef struct packed {
    logic xtalHighRate;
    arcm_ocs_e outClockSel;
    arcm_mode_e clockOpMode;
  } arcm_ctrl_s;

  localparam arcm_ctrl_s CTRL_RST = '{xtalHighRate: 1'b0, outClockSel: OCS_256_256, clockOpMode: MODE_PLL};
endpackage : arcm_pkg

/* rtl/arcm_top.sv */
// receive clock source, mode control, rate indicator and compressed burst detect
//
// Overview of operation
// - Raise the compressed-stream output on five zero words followed by 0xF872 and 0x4E1F.
// - Hold it high until 4096 frames pass with no new sync, each sync restarting the count.
// - On each sync store the two following burst words into buffer registers 0x0D to 0x10.
// - From the recovered clock, the high-rate output is high at 88.2 kHz up to the 108 kHz lock limit, low at 54 kHz and below.
// - From the crystal, the high-rate output follows the crystal-mode high-rate setting.
// - Lock is lost whenever the interval between frame preambles is wrong.
// - Lock covers frame rates of 22 kHz to 108 kHz and is reached well inside 20 ms.
// - Both master clock outputs come from the selected source, recovered or crystal.
// - Output select 00 gives 256/256, 01 gives 256/128, 10 gives 512/256, 11 is test.
// - The two-bit clock mode picks the master clock source and the serial data source.
// - Mode 0 runs recovery only with received data; mode 1 runs the crystal only with auxiliary data.
// - Mode 2 uses recovery while locked and falls back to crystal and auxiliary data on unlock.
// - Mode 3 fixes crystal and auxiliary data while recovery keeps running.
// - Power-down low resets all registers, stops clocks and blocks register access.
`timescale 1ns/100ps
module arcm_top
  import arcm_pkg::*;
(
  // clock and power-down reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [arcm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [arcm_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [arcm_pkg::DATA_W-1:0] regRdData,
  // decoded receive stream
  input wire logic frameStb,
  input wire logic preambleErr,
  input wire logic wordStb,
  input wire logic [15:0] wordData,
  input wire logic rxAudio,
  input wire logic auxiliaryAudioIn,
  // source clock ticks, one per 512fs half period
  input wire logic pllTick,
  input wire logic xtalTick,
  // outputs
  output logic masterClockOutA,
  output logic masterClockOutB,
  output logic serialAudioOut,
  output logic highRateIndicator,
  output logic compressedOut,
  output logic pllEnable,
  output logic xtalEnable,
  output logic unlockOut,
  output logic irq
);
  import arcm_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_r;
  wire logic rstN = rstSync_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  function automatic logic inLockRange(input logic [PER_W-1:0] p);
    inLockRange = (p >= LOCK_MIN_CYC) && (p <= LOCK_MAX_CYC);
  endfunction : inLockRange

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  arcm_ctrl_s ctrl_r;
  logic [EV_W-1:0] event_r;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] evSet;
  logic [DATA_W-1:0] buf_r [4];
  logic [DATA_W-1:0] rdNxt;
  logic locked_r;
  logic useXtal;
  logic measHigh_r;

  // power-down holds everything in reset, so no access lands then
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      ctrl_r <= CTRL_RST;
    else if (regWrStb && regAddr == ADDR_CTRL)
      ctrl_r <= arcm_ctrl_s'(regWrData[CTRL_W-1:0]);
  end

  // sticky events, set beats a write-one clear
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      event_r <= '0;
    else if (regWrStb && regAddr == ADDR_EVENT)
      event_r <= (event_r & ~regWrData[EV_W-1:0]) | evSet;
    else
      event_r <= event_r | evSet;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      mask_r <= '0;
    else if (regWrStb && regAddr == ADDR_MASK)
      mask_r <= regWrData[EV_W-1:0];
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      irq <= 1'b0;
    else
      irq <= |(event_r & mask_r);
  end

  always_comb
  begin
    rdNxt = '0;
    case (regAddr)
      ADDR_CTRL: rdNxt = DATA_W'(ctrl_r);
      ADDR_EVENT: rdNxt = DATA_W'(event_r);
      ADDR_MASK: rdNxt = DATA_W'(mask_r);
      ADDR_STATE:
      begin
        rdNxt[ST_LOCK] = locked_r;
        rdNxt[ST_HIRATE] = highRateIndicator;
        rdNxt[ST_COMP] = compressedOut;
        rdNxt[ST_XTAL] = useXtal;
      end
      ADDR_BUF0: rdNxt = buf_r[0];
      ADDR_BUF1: rdNxt = buf_r[1];
      ADDR_BUF2: rdNxt = buf_r[2];
      ADDR_BUF3: rdNxt = buf_r[3];
      default: rdNxt = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      regRdData <= '0;
    else if (regRdStb)
      regRdData <= rdNxt;
    else
      regRdData <= '0;
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // recovery runs except in mode 1, crystal except in mode 0
  wire logic pllOn = (ctrl_r.clockOpMode != MODE_XTAL);
  wire logic xtalOn = (ctrl_r.clockOpMode != MODE_PLL);

  always_comb
  begin
    case (ctrl_r.clockOpMode)
      MODE_PLL: useXtal = 1'b0;
      MODE_XTAL: useXtal = 1'b1;
      MODE_AUTO: useXtal = !locked_r;
      MODE_MON: useXtal = 1'b1;
      default: useXtal = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pllEnable <= 1'b0;
      xtalEnable <= 1'b0;
      serialAudioOut <= 1'b0;
      highRateIndicator <= 1'b0;
    end
    else
    begin
      pllEnable <= pllOn;
      xtalEnable <= xtalOn;
      serialAudioOut <= useXtal ? auxiliaryAudioIn : rxAudio;
      highRateIndicator <= useXtal ? ctrl_r.xtalHighRate : measHigh_r;
    end
  end

  // ----------------------------------------------------------------
  // frame period, rate and lock
  // ----------------------------------------------------------------
  logic [PER_W-1:0] period_r;
  logic [3:0] goodCnt_r;
  wire logic frameOk = inLockRange(period_r) && !preambleErr;
  wire logic overdue = (period_r > LOCK_MAX_CYC);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      period_r <= '0;
    else if (frameStb || !pllOn)
      period_r <= '0;
    else if (period_r != PER_SAT)
      period_r <= period_r + 1'b1;
  end

  // measured rate with hysteresis between the two bands
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      measHigh_r <= 1'b0;
    else if (frameStb && frameOk && period_r <= HI_MAX_CYC)
      measHigh_r <= 1'b1;
    else if (frameStb && period_r >= LO_MIN_CYC)
      measHigh_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      goodCnt_r <= '0;
    else if (!pllOn || overdue || (frameStb && !frameOk))
      goodCnt_r <= '0;
    else if (frameStb && goodCnt_r != LOCK_FRAMES)
      goodCnt_r <= goodCnt_r + 1'b1;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      locked_r <= 1'b0;
    else if (!pllOn || overdue || (frameStb && !frameOk))
      locked_r <= 1'b0;
    else if (goodCnt_r == LOCK_FRAMES)
      locked_r <= 1'b1;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      unlockOut <= 1'b0;
    else
      unlockOut <= pllOn && !locked_r;
  end

  // ----------------------------------------------------------------
  // master clocks
  // ----------------------------------------------------------------
  logic [1:0] div_r;
  wire logic srcTick = useXtal ? (xtalOn && xtalTick) : (pllOn && pllTick);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      div_r <= '0;
    else if (srcTick)
      div_r <= div_r + 1'b1;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      masterClockOutA <= 1'b0;
      masterClockOutB <= 1'b0;
    end
    else
    begin
      case (ctrl_r.outClockSel)
        OCS_256_256:
        begin
          if (srcTick && div_r[0])
          begin
            masterClockOutA <= !masterClockOutA;
            masterClockOutB <= !masterClockOutB;
          end
        end
        OCS_256_128:
        begin
          if (srcTick && div_r[0])
            masterClockOutA <= !masterClockOutA;
          if (srcTick && div_r == 2'h3)
            masterClockOutB <= !masterClockOutB;
        end
        OCS_512_256:
        begin
          if (srcTick)
            masterClockOutA <= !masterClockOutA;
          if (srcTick && div_r[0])
            masterClockOutB <= !masterClockOutB;
        end
        default:
        begin
          masterClockOutA <= 1'b0;
          masterClockOutB <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // burst sync detect and preamble capture
  // ----------------------------------------------------------------
  arcm_burst_e bs_r;
  logic [2:0] zeros_r;
  logic syncHit;
  logic [FRM_W-1:0] idle_r;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      zeros_r <= '0;
    else if (wordStb)
      zeros_r <= (wordData != '0) ? '0 : (zeros_r == SYNC_ZERO_WORDS) ? zeros_r : zeros_r + 1'b1;
  end

  assign syncHit = wordStb && bs_r == BS_SAW_A && wordData == SYNC_WORD_B;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      bs_r <= BS_SEEK;
    else if (wordStb)
    begin
      case (bs_r)
        BS_SEEK: bs_r <= (zeros_r == SYNC_ZERO_WORDS && wordData == SYNC_WORD_A) ? BS_SAW_A : BS_SEEK;
        BS_SAW_A: bs_r <= syncHit ? BS_CAP_INFO : BS_SEEK;
        BS_CAP_INFO: bs_r <= BS_CAP_LEN;
        BS_CAP_LEN: bs_r <= BS_SEEK;
        default: bs_r <= BS_SEEK;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      buf_r[2] <= '0;
      buf_r[3] <= '0;
    end
    else if (wordStb && bs_r == BS_CAP_INFO)
    begin
      buf_r[0] <= wordData[7:0];
      buf_r[1] <= wordData[15:8];
    end
    else if (wordStb && bs_r == BS_CAP_LEN)
    begin
      buf_r[2] <= wordData[7:0];
      buf_r[3] <= wordData[15:8];
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      compressedOut <= 1'b0;
      idle_r <= '0;
    end
    else if (syncHit)
    begin
      compressedOut <= 1'b1;
      idle_r <= '0;
    end
    else if (frameStb && compressedOut)
    begin
      idle_r <= idle_r + 1'b1;
      if (idle_r == IDLE_LAST)
        compressedOut <= 1'b0;
    end
  end

  always_comb
  begin
    evSet = '0;
    evSet[EV_BURST] = syncHit;
    evSet[EV_UNLOCK] = locked_r && (!pllOn || overdue || (frameStb && !frameOk));
    evSet[EV_IDLE] = frameStb && compressedOut && !syncHit && idle_r == IDLE_LAST;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_syncTail;
    wordStb && bs_r == BS_SAW_A && wordData == SYNC_WORD_B;
  endsequence

  property p_syncSets;
    @(posedge clk) disable iff (!rstN) s_syncTail |=> compressedOut && idle_r == '0;
  endproperty
  a_syncSets: assert property (p_syncSets) else $error("sync did not raise compressed flag");

  property p_compHolds;
    @(posedge clk) disable iff (!rstN)
      $fell(compressedOut) |-> $past(idle_r) == IDLE_LAST && $past(frameStb);
  endproperty
  a_compHolds: assert property (p_compHolds) else $error("compressed flag dropped early");

  property p_capInfo;
    @(posedge clk) disable iff (!rstN)
      (wordStb && bs_r == BS_CAP_INFO) |=> buf_r[0] == $past(wordData[7:0]) && buf_r[1] == $past(wordData[15:8]);
  endproperty
  a_capInfo: assert property (p_capInfo) else $error("burst info word not stored");

  property p_capLen;
    @(posedge clk) disable iff (!rstN)
      (wordStb && bs_r == BS_CAP_LEN) |=> buf_r[2] == $past(wordData[7:0]) && buf_r[3] == $past(wordData[15:8]);
  endproperty
  a_capLen: assert property (p_capLen) else $error("burst length word not stored");

  property p_rateHigh;
    @(posedge clk) disable iff (!rstN)
      (frameStb && frameOk && period_r <= HI_MAX_CYC && !useXtal) ##1 !useXtal |=> highRateIndicator;
  endproperty
  a_rateHigh: assert property (p_rateHigh) else $error("high rate not shown");

  property p_xtalRate;
    @(posedge clk) disable iff (!rstN) useXtal |=> highRateIndicator == $past(ctrl_r.xtalHighRate);
  endproperty
  a_xtalRate: assert property (p_xtalRate) else $error("crystal high rate setting not shown");

  property p_badFrameUnlocks;
    @(posedge clk) disable iff (!rstN) (frameStb && !frameOk) |=> !locked_r;
  endproperty
  a_badFrameUnlocks: assert property (p_badFrameUnlocks) else $error("lock kept on bad interval");

  property p_lockGain;
    @(posedge clk) disable iff (!rstN) $rose(locked_r) |-> $past(goodCnt_r) == LOCK_FRAMES;
  endproperty
  a_lockGain: assert property (p_lockGain) else $error("lock without enough good frames");

  property p_dataSrc;
    @(posedge clk) disable iff (!rstN)
      $past(rstN) |-> serialAudioOut == ($past(useXtal) ? $past(auxiliaryAudioIn) : $past(rxAudio));
  endproperty
  a_dataSrc: assert property (p_dataSrc) else $error("serial data from wrong source");

  property p_autoFallback;
    @(posedge clk) disable iff (!rstN) (ctrl_r.clockOpMode == MODE_AUTO && !locked_r) |=>
      serialAudioOut == $past(auxiliaryAudioIn) && highRateIndicator == $past(ctrl_r.xtalHighRate);
  endproperty
  a_autoFallback: assert property (p_autoFallback) else $error("mode 2 kept recovered clock unlocked");

  property p_testStill;
    @(posedge clk) disable iff (!rstN)
      (ctrl_r.outClockSel == OCS_TEST) [*2] |-> !masterClockOutA && !masterClockOutB;
  endproperty
  a_testStill: assert property (p_testStill) else $error("master clocks run in test code");
endmodule : arcm_top

/* dv/arcm_tx_model.sv */
// far-side stream source: frames, data words, recovered clock ticks
`timescale 1ns/100ps
module arcm_tx_model (
  // clock and recovery enable
  input wire logic clk,
  input wire logic pllOn,
  // decoded stream toward the receiver
  output logic frameStb,
  output logic preambleErr,
  output logic wordStb,
  output logic [15:0] wordData,
  output logic rxAudio,
  output logic pllTick
);
  int period = 0;
  int burstLeft = 0;
  int cnt = 0;
  int seed = 50;
  logic badPre = 1'b0;
  logic fire;
  logic [15:0] wq[$];

  initial
  begin
    {frameStb, preambleErr, wordStb, rxAudio, pllTick} = 5'h00;
    wordData = 16'h0000;
  end

  // fast frame burst has priority over the free-running frame rate
  always @(posedge clk)
  begin
    cnt <= cnt + 1;
    fire = (burstLeft > 0) ? (cnt % 2 == 0) : (period > 0 && cnt % period == 0);
    if (burstLeft > 0 && fire)
      burstLeft <= burstLeft - 1;
    frameStb <= fire;
    preambleErr <= fire & badPre;
    wordStb <= (wq.size() > 0);
    // idle data lines wander rather than hold the last word
    wordData <= (wq.size() > 0) ? wq.pop_front() : 16'($random(seed));
    pllTick <= (cnt % 2 == 0) & pllOn;
    rxAudio <= 1'($random(seed));
  end

  task push(input logic [15:0] w);
    wq.push_back(w);
  endtask : push

  task frames(input int n);
    @(negedge clk);
    burstLeft = n;
    wait (burstLeft == 0);
  endtask : frames
endmodule : arcm_tx_model

/* dv/arcm_top_tb.sv */
// self-checking bench for the receive clock, mode and burst-detect block
`timescale 1ns/100ps
module arcm_top_tb;
  import arcm_pkg::*;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic auxiliaryAudioIn = 1'b0;
  logic xtalTick = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData;
  logic frameStb, preambleErr, wordStb, rxAudio, pllTick, src, prevA, prevB;
  logic [15:0] wordData, pc, pd;
  logic masterClockOutA, masterClockOutB, serialAudioOut, highRateIndicator;
  logic compressedOut, pllEnable, xtalEnable, unlockOut, irq;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 50;
  int cyc = 0;
  int togA = 0;
  int togB = 0;
  int m, xs, expLock, exA, exB;
  logic [7:0] expBuf[4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  int modes[5] = '{0, 2, 3, 1, 2};
  int divA[4] = '{2, 2, 1, 0};
  int divB[4] = '{2, 4, 2, 0};

  arcm_top u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .frameStb(frameStb), .preambleErr(preambleErr),
    .wordStb(wordStb), .wordData(wordData), .rxAudio(rxAudio), .auxiliaryAudioIn(auxiliaryAudioIn),
    .pllTick(pllTick), .xtalTick(xtalTick), .masterClockOutA(masterClockOutA),
    .masterClockOutB(masterClockOutB), .serialAudioOut(serialAudioOut), .highRateIndicator(highRateIndicator),
    .compressedOut(compressedOut), .pllEnable(pllEnable), .xtalEnable(xtalEnable), .unlockOut(unlockOut),
    .irq(irq));
  arcm_tx_model u_tx (.clk(clk), .pllOn(pllEnable), .frameStb(frameStb), .preambleErr(preambleErr),
    .wordStb(wordStb), .wordData(wordData), .rxAudio(rxAudio), .pllTick(pllTick));

  initial
  begin
    forever #50 clk = ~clk;
  end

  // crystal ticks, auxiliary data and clock edge counting
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    xtalTick <= (cyc % 4 == 0);
    auxiliaryAudioIn <= 1'($random(seed));
    prevA <= masterClockOutA;
    prevB <= masterClockOutB;
    if (masterClockOutA !== prevA)
      togA++;
    if (masterClockOutB !== prevB)
      togB++;
  end

  initial
  begin
    #6_000_000;
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task cwait(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cwait

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask : wr

  task rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    @(negedge clk);
    chk("regRdData", exp, regRdData);
  endtask : rchk

  task bufchk();
    for (int i = 0; i < 4; i++)
      rchk(ADDR_BUF0 + 5'(i), expBuf[i]);
  endtask : bufchk

  task sync(input logic [15:0] last, input logic [15:0] c, input logic [15:0] d);
    @(negedge clk);
    repeat (5) u_tx.push(16'h0000);
    u_tx.push(SYNC_WORD_A);
    u_tx.push(last);
    u_tx.push(c);
    u_tx.push(d);
    while (u_tx.wq.size() != 0)
      @(posedge clk);
    cwait(3);
    if (last === SYNC_WORD_B)
      expBuf = '{c[7:0], c[15:8], d[7:0], d[15:8]};
  endtask : sync

  task end_of_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    cwait(5);
    bufchk();
    rchk(ADDR_CTRL, 8'h00);
    rchk(ADDR_EVENT, 8'h00);
    rchk(ADDR_MASK, 8'h00);
    rchk(5'h1F, 8'h00);
    wr(ADDR_STATE, 8'hFF);
    rchk(ADDR_STATE, 8'h00);
    wr(ADDR_BUF0, 8'hFF);
    rchk(ADDR_BUF0, 8'h00);
    @(negedge clk) u_tx.period = 100;
    cwait(1400);
    expLock = 1;
    rchk(ADDR_STATE, 8'h03);
    chk("unlockOut", 0, unlockOut);
    @(negedge clk) u_tx.period = 200;
    cwait(1200);
    chk("highRate", 0, highRateIndicator);
    @(negedge clk) u_tx.badPre = 1'b1;
    cwait(250);
    @(negedge clk) u_tx.badPre = 1'b0;
    cwait(5);
    rchk(ADDR_STATE, 8'h00);
    chk("unlockOut", 1, unlockOut);
    rchk(ADDR_EVENT, 8'h02);
    wr(ADDR_EVENT, 8'h02);
    rchk(ADDR_EVENT, 8'h00);
    cwait(2000);
    for (int i = 0; i < 5; i++)
    begin
      m = modes[i];
      wr(ADDR_CTRL, 8'(16 + m));
      if (m == 1)
        expLock = 0;
      xs = (m != 0) && !(m == 2 && expLock == 1);
      cwait(4);
      rchk(ADDR_CTRL, 8'(16 + m));
      rchk(ADDR_STATE, 8'(expLock + 10 * xs));
      chk("pllEnable", m != 1, pllEnable);
      chk("xtalEnable", m != 0, xtalEnable);
      chk("unlockOut", m != 1 && expLock == 0, unlockOut);
      chk("highRate", xs, highRateIndicator);
      repeat (4)
      begin
        @(negedge clk) src = xs ? auxiliaryAudioIn : rxAudio;
        @(negedge clk) chk("serialOut", src, serialAudioOut);
      end
    end
    for (int mm = 0; mm < 2; mm++)
      for (int s = 0; s < 4; s++)
      begin
        wr(ADDR_CTRL, 8'(4 * s + mm)); // select 10 only with a low-rate stream
        cwait(8);
        @(negedge clk);
        togA = 0;
        togB = 0;
        cwait(256);
        exA = divA[s] ? (128 >> mm) / divA[s] : 0;
        exB = divB[s] ? (128 >> mm) / divB[s] : 0;
        chk("mclkA", 1, (togA - exA) * (togA - exA) <= (exA != 0));
        chk("mclkB", 1, (togB - exB) * (togB - exB) <= (exB != 0));
      end
    wr(ADDR_CTRL, 8'h00);
    cwait(2000);
    wr(ADDR_EVENT, 8'h07);
    sync(16'h1234, 16'h0015, 16'h0100);
    chk("compressed", 0, compressedOut);
    rchk(ADDR_EVENT, 8'h00);
    pc = 16'($random(seed));
    pd = 16'($random(seed));
    sync(SYNC_WORD_B, pc, pd);
    chk("compressed", 1, compressedOut);
    bufchk();
    rchk(ADDR_EVENT, 8'h01);
    chk("irq", 0, irq);
    wr(ADDR_MASK, 8'h01);
    cwait(3);
    chk("irq", 1, irq);
    wr(ADDR_EVENT, 8'h01);
    cwait(3);
    chk("irq", 0, irq);
    @(negedge clk) u_tx.period = 0;
    cwait(300);
    u_tx.frames(2000);
    pc = 16'($random(seed));
    pd = 16'($random(seed));
    sync(SYNC_WORD_B, pc, pd);
    bufchk();
    u_tx.frames(4095);
    cwait(3);
    chk("compressed", 1, compressedOut);
    u_tx.frames(1);
    cwait(3);
    chk("compressed", 0, compressedOut);
    rchk(ADDR_EVENT, 8'h07);
    @(posedge clk) rst_b <= 1'b0;
    cwait(2);
    chk("mclkA", 0, masterClockOutA);
    chk("pllEnable", 0, pllEnable);
    wr(ADDR_CTRL, 8'h1F);
    rchk(ADDR_CTRL, 8'h00);
    @(posedge clk) rst_b <= 1'b1;
    cwait(5);
    rchk(ADDR_CTRL, 8'h00);
    expBuf = '{8'h00, 8'h00, 8'h00, 8'h00};
    bufchk();
    chk("compressed", 0, compressedOut);
    end_of_test();
  end
endmodule : arcm_top_tb
